/* File: logic/pvs_map.svh */
// Purpose: register offsets, field positions, reset values and frame constants
// Assumes: 5-bit register addresses on the management bus
// Notes: included by bare name; definitions only
`ifndef PVS_MAP_SVH
`define PVS_MAP_SVH

`define PVS_OFS_RXERR 5'h15
`define PVS_OFS_INT 5'h1B
`define PVS_OFS_CTRL 5'h1F

`define PVS_B_PAIRSWAP 13
`define PVS_B_ENERGY 12
`define PVS_B_FORCE 11
`define PVS_B_PSAVE 10
`define PVS_B_IRQPOL 9
`define PVS_B_JABEN 8
`define PVS_B_ANDONE 7
`define PVS_B_PAUSE 6
`define PVS_B_ISO 5
`define PVS_B_MODE_HI 4
`define PVS_B_MODE_LO 2
`define PVS_B_SQE 1
`define PVS_B_SCRAM 0

`define PVS_RST_CNT 16'h0000
`define PVS_RST_INT_EN 8'h00
`define PVS_RST_FLAGS 8'h00
`define PVS_RST_PAIRSWAP 1'b0
`define PVS_RST_FORCE 1'b0
`define PVS_RST_PSAVE 1'b1
`define PVS_RST_IRQPOL 1'b0
`define PVS_RST_JABEN 1'b1
`define PVS_RST_SQE 1'b0
`define PVS_RST_SCRAM 1'b0

`define PVS_OP_RD 2'h2
`define PVS_OP_WR 2'h1
`define PVS_PRE_BITS 32

`endif

/* File: logic/pvs_pkg.sv */
// Purpose: shared types of the vendor status and control registers
// Assumes: nothing beyond the map header
// Notes: struct field order matches the register bit order
package pvs_pkg;

  typedef enum logic [2:0] {
    PVS_S_PRE = 3'h0,
    PVS_S_ST = 3'h1,
    PVS_S_OP = 3'h3,
    PVS_S_PHYAD = 3'h2,
    PVS_S_REGAD = 3'h6,
    PVS_S_TA = 3'h7,
    PVS_S_DATA = 3'h5
  } pvs_state_t;

  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_rx;
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } pvs_events_t;

  typedef struct packed {
    logic energy_detect;
    logic an_complete;
    logic pause_result;
    logic isolate_status;
    logic [2:0] op_mode;
  } pvs_status_t;

  typedef struct packed {
    logic pairswap_dis;
    logic force_link;
    logic power_save_en;
    logic irq_active_high;
    logic jabber_en;
    logic sqe_test_en;
    logic scramble_dis;
  } pvs_ctrl_t;

  typedef struct packed {
    logic pairswap_dis;
    logic power_save_en;
  } pvs_strap_t;

endpackage

/* File: logic/pvs_rxerr_cnt.sv */
// Purpose: receive error counter
// Assumes: rx_dv and rx_er synchronous to clk
// Notes: one count per error burst inside a packet; holds at all ones
`timescale 1ns/1ps
`include "pvs_map.svh"

module pvs_rxerr_cnt #(
  parameter int CNT_W = 16
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic rx_dv, // receive data valid
  input wire logic rx_er, // receive error indication
  output logic [CNT_W-1:0] count, // error count
  output logic err_pulse // one-cycle pulse per error burst, also after the count holds at all ones
);

  logic er_q;
  logic hit;

  assign hit = rx_dv & rx_er & ~er_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      er_q <= 1'b0;
    end else begin
      er_q <= rx_dv & rx_er;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= CNT_W'(`PVS_RST_CNT);
    end else if (hit && count != {CNT_W{1'b1}}) begin
      count <= count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_pulse <= 1'b0;
    end else begin
      err_pulse <= hit;
    end
  end

endmodule

/* File: logic/pvs_regs.sv */
// Purpose: vendor status and control registers behind the management interface
// Assumes: mdc and mdio_in synchronous to clk, mdc far slower than clk
// Notes: read data changes after each mdc rising edge; straps load once after reset
`timescale 1ns/1ps
`include "pvs_map.svh"

// Contract
// - read-only error counter, reset to zero
// - upper interrupt bits are enables, reset zero
// - lower bits are sticky event flags
// - polarity bit selects interrupt active level
// - pair-swap disable turns off auto crossover
// - energy detect shows receive signal present
// - force link bypasses link control
// - power saving enable, reset one
// - jabber counter enable, reset one
// - auto-negotiation complete status bit
// - pause result shows flow control capability
// - isolate status shows isolate mode
// - three-bit operating mode indication
// - SQE test enable, reset zero
// - scrambler disable, reset zero
// - some reset values come from straps
module pvs_regs #(
  parameter int PREAMBLE_BITS = `PVS_PRE_BITS,
  parameter int CNT_W = 16
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic mdc, // management clock, sampled
  input wire logic mdio_in, // management data in
  output logic mdio_out, // management data out
  output logic mdio_oe, // management data drive enable
  input wire logic [4:0] phy_addr, // this device's bus address
  input wire logic rx_dv, // receive data valid
  input wire logic rx_er, // receive error
  input pvs_pkg::pvs_events_t events, // event pulses from the core
  input pvs_pkg::pvs_status_t status, // live status from the core
  input pvs_pkg::pvs_strap_t straps, // strap levels
  output pvs_pkg::pvs_ctrl_t ctrl, // control bits to the core
  output logic irq_out // interrupt pin level
);

  localparam int PRE_W = $clog2(PREAMBLE_BITS + 1);
  localparam logic [PRE_W-1:0] PRE_MAX = PRE_W'(PREAMBLE_BITS);

  generate
    if (PREAMBLE_BITS < 1 || PREAMBLE_BITS > 64) begin : g_bad_pre
      $error("PREAMBLE_BITS out of range");
    end
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
      $error("CNT_W must be 1 to 16");
    end
  endgenerate

  pvs_pkg::pvs_state_t state;
  logic [PRE_W-1:0] pre_cnt;
  logic [3:0] cnt;
  logic [15:0] sr;
  logic [15:0] rd_buf;
  logic [15:0] rdata;
  logic [4:0] regad;
  logic is_rd;
  logic phy_hit;
  logic mdc_q;
  logic mdc_rise;
  logic rd_req;
  logic wr_req;
  logic strap_done;
  pvs_pkg::pvs_ctrl_t ctrl_q;
  logic [7:0] int_en;
  logic [7:0] flags;
  logic [7:0] ev_all;
  logic [7:0] next_flags;
  logic [CNT_W-1:0] err_count;
  logic err_pulse;
  logic rd_clr;
  logic wr_int;
  logic wr_ctrl;

  pvs_rxerr_cnt #(
    .CNT_W(CNT_W)
  ) u_rxerr (
    .clk(clk),
    .nrst(nrst),
    .rx_dv(rx_dv),
    .rx_er(rx_er),
    .count(err_count),
    .err_pulse(err_pulse)
  );

  assign mdc_rise = mdc & ~mdc_q;
  assign ctrl = ctrl_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end

  // serial frame decoder: preamble, start, opcode, addresses, turnaround, data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= pvs_pkg::PVS_S_PRE;
      pre_cnt <= '0;
      cnt <= 4'h0;
      sr <= 16'h0000;
      regad <= 5'h00;
      is_rd <= 1'b0;
      phy_hit <= 1'b0;
    end else if (mdc_rise) begin
      case (state)
        pvs_pkg::PVS_S_PRE: begin
          if (mdio_in) begin
            if (pre_cnt != PRE_MAX) begin
              pre_cnt <= pre_cnt + PRE_W'(1);
            end
          end else if (pre_cnt == PRE_MAX) begin
            state <= pvs_pkg::PVS_S_ST;
            pre_cnt <= '0;
          end else begin
            pre_cnt <= '0;
          end
        end
        pvs_pkg::PVS_S_ST: begin
          cnt <= 4'h0;
          state <= mdio_in ? pvs_pkg::PVS_S_OP : pvs_pkg::PVS_S_PRE;
        end
        pvs_pkg::PVS_S_OP: begin
          sr <= {sr[14:0], mdio_in};
          if (cnt == 4'h1) begin
            cnt <= 4'h0;
            if ({sr[0], mdio_in} == `PVS_OP_RD) begin
              is_rd <= 1'b1;
              state <= pvs_pkg::PVS_S_PHYAD;
            end else if ({sr[0], mdio_in} == `PVS_OP_WR) begin
              is_rd <= 1'b0;
              state <= pvs_pkg::PVS_S_PHYAD;
            end else begin
              state <= pvs_pkg::PVS_S_PRE;
            end
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        pvs_pkg::PVS_S_PHYAD: begin
          sr <= {sr[14:0], mdio_in};
          if (cnt == 4'h4) begin
            cnt <= 4'h0;
            phy_hit <= ({sr[3:0], mdio_in} == phy_addr);
            state <= pvs_pkg::PVS_S_REGAD;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        pvs_pkg::PVS_S_REGAD: begin
          sr <= {sr[14:0], mdio_in};
          if (cnt == 4'h4) begin
            cnt <= 4'h0;
            regad <= {sr[3:0], mdio_in};
            state <= pvs_pkg::PVS_S_TA;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        pvs_pkg::PVS_S_TA: begin
          if (cnt == 4'h1) begin
            cnt <= 4'h0;
            state <= pvs_pkg::PVS_S_DATA;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        pvs_pkg::PVS_S_DATA: begin
          sr <= {sr[14:0], mdio_in};
          if (cnt == 4'hF) begin
            cnt <= 4'h0;
            state <= pvs_pkg::PVS_S_PRE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        default: begin
          state <= pvs_pkg::PVS_S_PRE;
          pre_cnt <= '0;
          cnt <= 4'h0;
        end
      endcase
    end
  end

  // one-cycle access strobes, raised the cycle after the deciding mdc edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_req <= 1'b0;
      wr_req <= 1'b0;
    end else begin
      rd_req <= mdc_rise && state == pvs_pkg::PVS_S_REGAD && cnt == 4'h4 && is_rd &&
                phy_hit;
      wr_req <= mdc_rise && state == pvs_pkg::PVS_S_DATA && cnt == 4'hF && !is_rd &&
                phy_hit;
    end
  end

  // read data drive: zero in second turnaround bit, then msb first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
      rd_buf <= 16'h0000;
    end else if (rd_req) begin
      rd_buf <= rdata;
    end else if (mdc_rise && state == pvs_pkg::PVS_S_TA && is_rd && phy_hit) begin
      mdio_oe <= 1'b1;
      if (cnt == 4'h0) begin
        mdio_out <= 1'b0;
      end else begin
        mdio_out <= rd_buf[15];
        rd_buf <= {rd_buf[14:0], 1'b0};
      end
    end else if (mdc_rise && state == pvs_pkg::PVS_S_DATA && mdio_oe) begin
      if (cnt == 4'hF) begin
        mdio_oe <= 1'b0;
        mdio_out <= 1'b0;
      end else begin
        mdio_out <= rd_buf[15];
        rd_buf <= {rd_buf[14:0], 1'b0};
      end
    end
  end

  assign wr_int = wr_req && regad == `PVS_OFS_INT;
  assign wr_ctrl = wr_req && regad == `PVS_OFS_CTRL;
  assign rd_clr = rd_req && regad == `PVS_OFS_INT;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_done <= 1'b0;
    end else begin
      strap_done <= 1'b1;
    end
  end

  // control bits: constants under reset, straps at the first edge after release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q.pairswap_dis <= `PVS_RST_PAIRSWAP;
      ctrl_q.force_link <= `PVS_RST_FORCE;
      ctrl_q.power_save_en <= `PVS_RST_PSAVE;
      ctrl_q.irq_active_high <= `PVS_RST_IRQPOL;
      ctrl_q.jabber_en <= `PVS_RST_JABEN;
      ctrl_q.sqe_test_en <= `PVS_RST_SQE;
      ctrl_q.scramble_dis <= `PVS_RST_SCRAM;
    end else if (!strap_done) begin
      ctrl_q.pairswap_dis <= straps.pairswap_dis;
      ctrl_q.power_save_en <= straps.power_save_en;
    end else if (wr_ctrl) begin
      ctrl_q.pairswap_dis <= sr[`PVS_B_PAIRSWAP];
      ctrl_q.force_link <= sr[`PVS_B_FORCE];
      ctrl_q.power_save_en <= sr[`PVS_B_PSAVE];
      ctrl_q.irq_active_high <= sr[`PVS_B_IRQPOL];
      ctrl_q.jabber_en <= sr[`PVS_B_JABEN];
      ctrl_q.sqe_test_en <= sr[`PVS_B_SQE];
      ctrl_q.scramble_dis <= sr[`PVS_B_SCRAM];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_en <= `PVS_RST_INT_EN;
    end else if (wr_int) begin
      int_en <= sr[15:8];
    end
  end

  assign ev_all = events | {1'b0, err_pulse, 6'h00};

  // flags returned by a read clear; an event in that same cycle still sets
  always_comb begin
    next_flags = rd_clr ? ev_all : (flags | ev_all);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags <= `PVS_RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  // reset value is the inactive level of an active-low pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_out <= 1'b1;
    end else if ((flags & int_en) != 8'h00) begin
      irq_out <= ctrl_q.irq_active_high;
    end else begin
      irq_out <= ~ctrl_q.irq_active_high;
    end
  end

  // register read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    rdata = 16'h0000;
    case (regad)
      `PVS_OFS_RXERR: begin
        rdata[CNT_W-1:0] = err_count;
      end
      `PVS_OFS_INT: begin
        rdata = {int_en, flags};
      end
      `PVS_OFS_CTRL: begin
        rdata[`PVS_B_PAIRSWAP] = ctrl_q.pairswap_dis;
        rdata[`PVS_B_ENERGY] = status.energy_detect;
        rdata[`PVS_B_FORCE] = ctrl_q.force_link;
        rdata[`PVS_B_PSAVE] = ctrl_q.power_save_en;
        rdata[`PVS_B_IRQPOL] = ctrl_q.irq_active_high;
        rdata[`PVS_B_JABEN] = ctrl_q.jabber_en;
        rdata[`PVS_B_ANDONE] = status.an_complete;
        rdata[`PVS_B_PAUSE] = status.pause_result;
        rdata[`PVS_B_ISO] = status.isolate_status;
        rdata[`PVS_B_MODE_HI:`PVS_B_MODE_LO] = status.op_mode;
        rdata[`PVS_B_SQE] = ctrl_q.sqe_test_en;
        rdata[`PVS_B_SCRAM] = ctrl_q.scramble_dis;
      end
      default: begin
        rdata = 16'h0000;
      end
    endcase
  end

endmodule

/* File: verification/pvs_mgmt_model.sv */
// Purpose: station manager model that sends management frames
// Assumes: shared data line has a pull-up, resolved by the bench
// Notes: mdc phases of three clk cycles; mdc idles low between frames
`timescale 1ns/1ps
module pvs_mgmt_model #(
  parameter int PRE = 4
) (
  input wire logic clk, // system clock
  input wire logic line, // resolved data line
  output logic mdc, // management clock
  output logic drv, // model data level
  output logic drv_oe // model drives the line
);
  initial begin
    mdc = 1'h0;
    drv = 1'h1;
    drv_oe = 1'h0;
  end

  // full preamble on every frame; line released for turnaround and data of reads
  task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] f;
    f = {2'h1, rd ? 2'h2 : 2'h1, pa, ra, 2'h2, wd};
    for (int i = -PRE; i < 32; i++) begin
      drv_oe = !(rd && i >= 14);
      drv = (i < 0) ? 1'h1 : f[31-i];
      repeat (3) @(negedge clk);
      if (i >= 16) q = {q[14:0], line};
      mdc = 1'h1;
      repeat (3) @(negedge clk);
      mdc = 1'h0;
    end
    drv_oe = 1'h0;
    // idle gap so a following frame never re-drives the line in the same step
    repeat (3) @(negedge clk);
  endtask
endmodule

/* File: verification/pvs_regs_assertions.sv */
// Purpose: port-level checks of the status and control registers
// Assumes: mdc slow against clk
// Notes: age counters measure clocks since the last mdc high or event
`timescale 1ns/1ps
module pvs_regs_checker (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic mdc, // management clock
  input wire logic mdio_out, // data out
  input wire logic mdio_oe, // drive enable
  input wire logic rx_dv, // receive data valid
  input wire logic rx_er, // receive error
  input pvs_pkg::pvs_events_t events, // event pulses
  input pvs_pkg::pvs_strap_t straps, // strap levels
  input pvs_pkg::pvs_ctrl_t ctrl, // control bits
  input wire logic irq_out // interrupt pin
);
  logic [3:0] age;
  logic [3:0] evt_age;
  logic seen;
  logic act;
  logic evt;
  assign act = irq_out ~^ ctrl.irq_active_high;
  assign evt = (events != 8'h00) || (rx_dv && rx_er);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) age <= 4'hF;
    else if (mdc) age <= 4'h0;
    else if (age != 4'hF) age <= age + 4'h1;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evt_age <= 4'hF;
      seen <= 1'h0;
    end else if (evt) begin
      evt_age <= 4'h0;
      seen <= 1'h1;
    end else if (evt_age != 4'hF) evt_age <= evt_age + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reset_ctrl_vals: assert property ($rose(nrst) |->
    ctrl.jabber_en && !ctrl.force_link && !ctrl.irq_active_high && !ctrl.sqe_test_en &&
    !ctrl.scramble_dis && irq_out && !mdio_oe)
    else $error("control reset values wrong");
  a_strap_capture: assert property ($rose(nrst) |=>
    ctrl.pairswap_dis == $past(straps.pairswap_dis) &&
    ctrl.power_save_en == $past(straps.power_save_en))
    else $error("strap values not taken");
  a_ctrl_by_write: assert property ($changed(ctrl) && $past(nrst, 2) |->
    age < 4'h5)
    else $error("control changed without a frame");
  a_irq_pol_follow: assert property ($changed(ctrl.irq_active_high) |=>
    $changed(irq_out))
    else $error("interrupt pin ignores polarity");
  a_irq_needs_event: assert property (act && $stable(ctrl.irq_active_high) |-> seen)
    else $error("interrupt active with no event");
  a_irq_rise_cause: assert property ($rose(act) && $stable(ctrl.irq_active_high) |->
    evt_age < 4'h4 || age < 4'h6)
    else $error("interrupt rose without cause");
  a_irq_clear_read: assert property ($fell(act) && $stable(ctrl.irq_active_high) |->
    age < 4'h6)
    else $error("interrupt dropped without access");
  a_ta_drive_low: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround not driven low");
  c_irq: cover property ($rose(act));
  c_read: cover property ($rose(mdio_oe));
  c_pol: cover property ($changed(ctrl.irq_active_high));
  c_strap: cover property ($rose(nrst) ##1 $changed(ctrl));
endmodule

bind pvs_regs pvs_regs_checker chk_i (.clk(clk), .nrst(nrst), .mdc(mdc),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .rx_dv(rx_dv), .rx_er(rx_er), .events(events),
  .straps(straps), .ctrl(ctrl), .irq_out(irq_out));

/* File: verification/testbench.sv */
// Purpose: self-checking bench of the status and control registers
// Assumes: short preamble parameter, pull-up on the data line
// Notes: random values from a fixed seed
`timescale 1ns/1ps
`include "pvs_map.svh"
module testbench;
  localparam int PRE = 4;
  logic clk, nrst, mdio_out, mdio_oe, rx_dv, rx_er, irq_out, mdc, drv, drv_oe, line;
  logic [4:0] phy_addr;
  pvs_pkg::pvs_events_t events;
  pvs_pkg::pvs_status_t status;
  pvs_pkg::pvs_strap_t straps;
  pvs_pkg::pvs_ctrl_t ctrl;
  logic [15:0] q, w, rw;
  logic [7:0] en, fl;
  int n_fail = 0;
  int cmp_count = 0;
  int nb;
  assign line = mdio_oe ? mdio_out : (drv_oe ? drv : 1'h1);
  pvs_regs #(.PREAMBLE_BITS(PRE)) DUT (.clk(clk), .nrst(nrst), .mdc(mdc), .mdio_in(line),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(phy_addr), .rx_dv(rx_dv), .rx_er(rx_er),
    .events(events), .status(status), .straps(straps), .ctrl(ctrl), .irq_out(irq_out));
  pvs_mgmt_model #(.PRE(PRE)) mgr (.clk(clk), .line(line), .mdc(mdc), .drv(drv),
    .drv_oe(drv_oe));

  function automatic logic [15:0] exp1f(input logic [15:0] r, input pvs_pkg::pvs_status_t s);
    return (r & 16'h2F03) | {3'h0, s.energy_detect, 4'h0, s.an_complete, s.pause_result,
      s.isolate_status, s.op_mode, 2'h0};
  endfunction
  function automatic logic [15:0] exp_ct(input logic [15:0] r);
    return {9'h0, r[13], r[11], r[10], r[9], r[8], r[1], r[0]};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t pin %b exp %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] ra);
    mgr.xfer(1'h1, phy_addr, ra, 16'h0000, q);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    mgr.xfer(1'h0, phy_addr, ra, d, q);
  endtask
  // reset, release, then check reset and strap values; straps flip so a later run differs
  task automatic reset_run(input int n);
    nrst = 1'h0;
    repeat (n) @(negedge clk);
    nrst = 1'h1;
    rw = 16'h0100;
    rw[13] = straps.pairswap_dis;
    rw[10] = straps.power_save_en;
    @(negedge clk);
    straps = ~straps;
    chk({9'h0, ctrl}, exp_ct(rw));
    chk_pin(irq_out, 1'h1);
    rd(`PVS_OFS_RXERR);
    chk(q, 16'h0000);
    rd(`PVS_OFS_INT);
    chk(q, 16'h0000);
    rd(`PVS_OFS_CTRL);
    chk(q, exp1f(rw, status));
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // about forty frames of some 220 cycles each; limit at 20000 cycles
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  initial begin
    void'($urandom(95));
    rx_dv = 1'h0;
    rx_er = 1'h0;
    events = 8'h00;
    phy_addr = 5'($urandom);
    status = 7'($urandom);
    straps = 2'($urandom);
    reset_run(12);
    for (int i = 0; i < 8; i++) begin
      status = 7'($urandom);
      status.op_mode = 3'(i);
      w = (i == 7) ? 16'hFFFF : ((i == 6) ? 16'h0000 : 16'($urandom));
      wr(`PVS_OFS_CTRL, w);
      rw = w;
      rd(`PVS_OFS_CTRL);
      chk(q, exp1f(rw, status));
      chk({9'h0, ctrl}, exp_ct(rw));
    end
    mgr.xfer(1'h0, ~phy_addr, `PVS_OFS_CTRL, ~rw, q);
    mgr.xfer(1'h1, ~phy_addr, `PVS_OFS_CTRL, 16'h0000, q);
    chk(q, 16'hFFFF);
    wr(`PVS_OFS_RXERR, 16'h5A5A);
    rd(5'h02);
    chk(q, 16'h0000);
    chk({9'h0, ctrl}, exp_ct(rw));
    nb = 3 + $urandom % 5;
    for (int i = 0; i < nb; i++) begin
      rx_dv = 1'h1;
      rx_er = 1'h1;
      repeat (1 + $urandom % 4) @(negedge clk);
      rx_er = 1'h0;
      repeat (2) @(negedge clk);
    end
    rx_dv = 1'h0;
    rx_er = 1'h1;
    repeat (3) @(negedge clk);
    rx_er = 1'h0;
    rd(`PVS_OFS_RXERR);
    chk(q, 16'(nb));
    rd(`PVS_OFS_INT);
    chk(q, 16'h0040);
    rd(`PVS_OFS_RXERR);
    chk(q, 16'(nb));
    en = 8'h81 | 8'($urandom);
    wr(`PVS_OFS_INT, {en, 8'hFF});
    for (int i = 0; i < 8; i++) begin
      fl = 8'h01 << i;
      events = fl;
      @(negedge clk);
      events = 8'h00;
      repeat (3) @(negedge clk);
      chk_pin(irq_out, (|(fl & en)) ? rw[9] : !rw[9]);
      rd(`PVS_OFS_INT);
      chk(q, {en, fl});
      chk_pin(irq_out, !rw[9]);
      if (i == 3) begin
        rw = rw ^ 16'h0200;
        wr(`PVS_OFS_CTRL, rw);
      end
    end
    // mid-run reset: counter, enables and control return to reset and strap values
    reset_run(3);
    conclude();
  end
endmodule
